// ===== dbtc_pkg.sv
package dbtc_pkg;
    // fixed core locations used by the break channel
    localparam logic [11:0] WORD_COUNT_LOC    = 12'hFE8;
    localparam logic [11:0] CURRENT_ADDR_LOC  = 12'hFE9;

    // disk address layout: angle, track, disk
    localparam int          ADDR_W            = 20;
    localparam int          ANGLE_W           = 11;
    localparam int          TRACK_LSB         = 11;
    localparam int          DISK_LSB          = 18;
    localparam logic [10:0] ANGLE_LAST        = 11'h7FF;

    // timing, clock at 125 MHz
    localparam int          CLK_MHZ           = 125;
    localparam int          ORIGIN_DELAY_NS   = 50000;
    localparam int          ORIGIN_WIDTH_NS   = 100000;
    localparam int          ORIGIN_DELAY_CYC  = ORIGIN_DELAY_NS * CLK_MHZ / 1000;
    localparam int          ORIGIN_WIDTH_CYC  = ORIGIN_WIDTH_NS * CLK_MHZ / 1000;
    localparam logic [4:0]  SYNC_WORDS        = 5'h10;

    // io pulse phase bit positions
    localparam int          PH1               = 0;
    localparam int          PH2               = 1;
    localparam int          PH4               = 2;

    // status word bit positions
    localparam int          ST_DONE           = 0;
    localparam int          ST_ORIGIN         = 1;
    localparam int          ST_ACTIVE         = 2;
    localparam int          ST_WLOCK          = 3;
    localparam int          ST_EIE            = 4;
    localparam int          ST_PIE            = 5;
    localparam int          ST_CIE            = 6;
    localparam int          ST_LATE           = 7;
    localparam int          ST_NXD            = 8;
    localparam int          ST_PARITY         = 9;
    localparam int          ST_EXT_LSB        = 10;

    // high address load bit positions within the accumulator
    localparam int          HI_MSB_AC         = 7;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SYNC   = 2'b01,
        ST_SEARCH = 2'b11,
        ST_XFER   = 2'b10
    } dbtc_state_t;

    typedef enum logic [3:0] {
        OP_NONE       = 4'h0,
        OP_READ_START = 4'h1,
        OP_WRITE_START= 4'h2,
        OP_HI_LOAD    = 4'h3,
        OP_HI_READ    = 4'h4,
        OP_HI_CLEAR   = 4'h5,
        OP_STAT_LOAD  = 4'h6,
        OP_STAT_READ  = 4'h7,
        OP_LOW_READ   = 4'h8
    } dbtc_op_t;
endpackage

// ===== dbtc_sync.sv
`timescale 1ns/1ps
module dbtc_sync (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic [2:0] stage;

    // the level only moves once the second and third stages agree
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage   <= 3'h0;
            level_o <= 1'b0;
        end else begin
            stage <= {stage[1:0], pin_i};
            if (stage[1] == stage[2]) begin
                level_o <= stage[2];
            end
        end
    end
endmodule

// ===== dbtc_top.sv
`timescale 1ns/1ps
// Function
// RULE_01 - disk address is 20 bits: low 12 from AC on start, high 8 from AC bits 4-11
// RULE_02 - address splits into 11-bit angle, 7-bit track, 2-bit disk
// RULE_03 - high address read clears AC at phase 1, drives it at phase 4, top bits zero
// RULE_04 - top high bit is written by start instructions; high load touches bits 1-7
// RULE_05 - word count and current address live at fixed core locations 7750, 7751
// RULE_06 - processor keeps negative count and address minus one, pre-incrementing it
// RULE_07 - write start raises a break; each written word raises the next
// RULE_08 - overflow on the last write word ends it; address stays on last word
// RULE_09 - read start searches, then each word goes to hold with a break request
// RULE_10 - read ends on overflow with address one past last word read
// RULE_11 - origin flag rises 50 us after angle 3777 and stays 100 us
// RULE_12 - start during origin flag skips the 16-word sync delay
// RULE_13 - active status bit shows search or transfer in progress
// RULE_14 - write-lock bit set only on locked write start; locked area never written
// RULE_15 - error enable raises interrupt on any error flag
// RULE_16 - origin enable raises interrupt while origin flag stands
// RULE_17 - completion enable raises interrupt on completion
// RULE_18 - late flag set when a break request was not honoured in time
// RULE_19 - missing-disk flag set when the selected disk is absent
// RULE_20 - parity flag set at end of a bad read word
// RULE_21 - transfer keeps going after errors until the overflow pulse
// RULE_22 - transfer crosses disks by itself and resynchronises
// RULE_23 - past last present disk sets missing flag; four disks wrap quietly
// RULE_24 - 16 word times of resync after each disk or track change
// RULE_25 - one interrupt line, OR of all enabled conditions
module dbtc_top
    import dbtc_pkg::*;
#(
    parameter int ORG_DELAY_CYC = ORIGIN_DELAY_CYC,
    parameter int ORG_WIDTH_CYC = ORIGIN_WIDTH_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic [3:0]  io_opcode_i,
    input  wire logic [2:0]  io_pulse_phase_i,
    input  wire logic [11:0] ac_i,
    input  wire logic        break_ack_i,
    input  wire logic        count_overflow_pulse_i,
    input  wire logic [11:0] mb_i,
    input  wire logic        disk_word_tick_i,
    input  wire logic        disk_index_i,
    input  wire logic [11:0] disk_rd_word_i,
    input  wire logic        disk_rd_parity_i,
    input  wire logic        write_locked_i,
    input  wire logic [3:0]  disk_present_i,
    output logic             break_request_o,
    output logic [11:0]      buffer_hold_register_o,
    output logic [11:0]      word_count_location_o,
    output logic [11:0]      current_address_location_o,
    output logic [1:0]       mem_ext_o,
    output logic [1:0]       disk_sel_o,
    output logic [6:0]       track_sel_o,
    output logic             disk_wr_en_o,
    output logic [11:0]      disk_wr_word_o,
    output logic [11:0]      ac_data_o,
    output logic             ac_load_o,
    output logic             ac_clear_o,
    output logic             irq_o
);
    localparam logic [13:0] DLY_LAST = 14'(ORG_DELAY_CYC - 1);
    localparam logic [13:0] WID_LAST = 14'(ORG_WIDTH_CYC - 1);

    // odd parity over the word and its parity bit
    function automatic logic parity_bad(input logic [11:0] w, input logic p);
        parity_bad = ~(^{w, p});
    endfunction

    logic [1:0]   rst_sync;
    logic         rst_n;
    logic [1:0]   pin_lvl;
    logic [1:0]   pin_d;
    logic [19:0]  addr;
    logic         msb_stage;
    logic [10:0]  angle_cnt;
    logic [4:0]   sync_cnt;
    logic [13:0]  org_cnt;
    logic         org_wait;
    logic         origin_sync_flag;
    dbtc_state_t  state;
    logic         mode_wr;
    logic         break_request;
    logic [11:0]  hold;
    logic         hold_full;
    logic         last_pending;
    logic         start_chk;
    logic         completion_flag;
    logic         write_lock_bit;
    logic         late_request_flag;
    logic         missing_disk_flag;
    logic         parity_flag;
    logic         error_irq_enable;
    logic         origin_irq_enable;
    logic         completion_irq_enable;
    logic [1:0]   mem_ext;

    // reset is released through two flops; assertion stays asynchronous
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // disk timing pins come from the drive's clock world
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            dbtc_sync u_sync (
                .sys_clk_i (sys_clk_i),
                .rst_n_i   (rst_n),
                .pin_i     (gi == 0 ? disk_word_tick_i : disk_index_i),
                .level_o   (pin_lvl[gi])
            );
        end
    endgenerate

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_d <= 2'h0;
        end else begin
            pin_d <= pin_lvl;
        end
    end

    // instruction and event decode
    wire        tick_rise   = pin_lvl[0] & ~pin_d[0];
    wire        index_rise  = pin_lvl[1] & ~pin_d[1];
    wire        ph1         = io_pulse_phase_i[PH1];
    wire        ph2         = io_pulse_phase_i[PH2];
    wire        ph4         = io_pulse_phase_i[PH4];
    wire        start_rd    = (io_opcode_i == OP_READ_START) & ph1;
    wire        start_wr    = (io_opcode_i == OP_WRITE_START) & ph1;
    wire        start_any   = start_rd | start_wr;
    wire        hi_clear    = ((io_opcode_i == OP_HI_LOAD) | (io_opcode_i == OP_HI_CLEAR)) & ph1;
    wire        hi_load     = (io_opcode_i == OP_HI_LOAD) & ph2;
    wire        hi_read_clr = (io_opcode_i == OP_HI_READ) & ph1;
    wire        stat_load   = (io_opcode_i == OP_STAT_LOAD) & ph4;
    wire        rd_clr      = ((io_opcode_i == OP_STAT_READ) | (io_opcode_i == OP_LOW_READ)) & ph2;
    wire        any_read    = ((io_opcode_i == OP_HI_READ) | (io_opcode_i == OP_STAT_READ)
                               | (io_opcode_i == OP_LOW_READ)) & ph4;
    wire [19:0] next_addr   = addr + 20'h00001;
    wire        track_cross = next_addr[10:0] == 11'h000;
    wire        at_target   = 11'(angle_cnt + 11'h001) == addr[10:0];
    wire        xfer_tick   = (state == ST_XFER) & tick_rise;
    wire        rd_tick     = xfer_tick & ~mode_wr;
    wire        wr_tick     = xfer_tick & mode_wr;
    wire        ack         = break_ack_i & break_request;
    wire        rd_done     = ack & count_overflow_pulse_i & ~mode_wr;
    wire        wr_done     = wr_tick & last_pending & hold_full;
    wire        advance     = rd_tick | (wr_tick & ~wr_done);
    wire        err_any     = write_lock_bit | late_request_flag | missing_disk_flag | parity_flag;
    wire [11:0] status_word = {mem_ext, parity_flag, missing_disk_flag, late_request_flag,
                               completion_irq_enable, origin_irq_enable, error_irq_enable,
                               write_lock_bit, state != ST_IDLE, origin_sync_flag, completion_flag}; // RULE_13
    wire [11:0] ac_mux      = (io_opcode_i == OP_HI_READ)  ? {4'h0, addr[19:12]} :   // RULE_03
                              (io_opcode_i == OP_LOW_READ) ? addr[11:0] : status_word;

    // address registers; the top high bit moves only on a start or on a carry out of bit 18 as the address steps
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr      <= 20'h00000;
            msb_stage <= 1'b0;
        end else if (start_any) begin
            addr[11:0] <= ac_i;               // RULE_01
            addr[19]   <= msb_stage;          // RULE_04
        end else if (hi_clear) begin
            addr[18:12] <= 7'h00;             // RULE_04
            msb_stage   <= 1'b0;
        end else if (hi_load) begin
            addr[18:12] <= ac_i[6:0];         // RULE_01
            msb_stage   <= ac_i[HI_MSB_AC];
        end else if (advance) begin
            addr <= next_addr;                // RULE_22 RULE_23
        end
    end

    // angle follows word ticks, index pulse marks angle zero
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            angle_cnt <= 11'h000;
        end else if (index_rise) begin
            angle_cnt <= 11'h000;
        end else if (tick_rise) begin
            angle_cnt <= 11'(angle_cnt + 11'h001);
        end
    end

    // origin mark is timed from the last angle word going by
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            org_cnt          <= 14'h0000;
            org_wait         <= 1'b0;
            origin_sync_flag <= 1'b0;
        end else if (tick_rise && angle_cnt == ANGLE_LAST) begin
            org_cnt          <= 14'h0000;     // RULE_11
            org_wait         <= 1'b1;
            origin_sync_flag <= 1'b0;
        end else if (org_wait) begin
            org_cnt <= 14'(org_cnt + 14'h0001);
            if (org_cnt == DLY_LAST) begin
                org_wait         <= 1'b0;
                origin_sync_flag <= 1'b1;     // RULE_11
                org_cnt          <= 14'h0000;
            end
        end else if (origin_sync_flag) begin
            org_cnt <= 14'(org_cnt + 14'h0001);
            if (org_cnt == WID_LAST) begin
                origin_sync_flag <= 1'b0;     // RULE_11
            end
        end
    end

    // sequencer: sync delay, search, transfer; a new start always restarts
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            sync_cnt <= 5'h00;
            mode_wr  <= 1'b0;
        end else if (start_any) begin
            mode_wr  <= start_wr;
            sync_cnt <= 5'h00;
            state    <= origin_sync_flag ? ST_SEARCH : ST_SYNC; // RULE_12
        end else begin
            case (state)
                ST_IDLE: begin
                    state <= ST_IDLE;
                end
                ST_SYNC: begin
                    if (tick_rise) begin
                        sync_cnt <= 5'(sync_cnt + 5'h01);
                        if (5'(sync_cnt + 5'h01) == SYNC_WORDS) begin
                            state <= ST_SEARCH;   // RULE_24
                        end
                    end
                end
                ST_SEARCH: begin
                    if (tick_rise && at_target) begin
                        state <= ST_XFER;         // RULE_09
                    end
                end
                ST_XFER: begin
                    if (rd_done || wr_done) begin
                        state <= ST_IDLE;         // RULE_21
                    end else if (advance && track_cross) begin
                        sync_cnt <= 5'h00;
                        state    <= ST_SYNC;      // RULE_22 RULE_24
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            if (rd_done) begin
                state <= ST_IDLE;                 // RULE_10
            end
        end
    end

    // hold register and break request; a word-tick request wins over an ack, an ack wins over a write start
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            break_request <= 1'b0;
            hold          <= 12'h000;
            hold_full     <= 1'b0;
            last_pending  <= 1'b0;
        end else begin
            if (start_any) begin
                break_request <= start_wr;        // RULE_07
                hold_full     <= 1'b0;
                last_pending  <= 1'b0;
            end
            if (wr_tick) begin
                hold_full <= 1'b0;
            end
            if (ack) begin
                break_request <= 1'b0;            // RULE_09
                if (mode_wr) begin
                    hold      <= mb_i;            // RULE_07
                    hold_full <= 1'b1;
                    if (count_overflow_pulse_i) begin
                        last_pending <= 1'b1;     // RULE_08
                    end
                end
            end
            if (rd_tick) begin
                hold          <= disk_rd_word_i;  // RULE_09
                break_request <= 1'b1;
            end
            if (wr_tick && !wr_done) begin
                break_request <= ~last_pending;   // RULE_07
            end
        end
    end

    // disk write port; lock input gates every write whatever the state
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            disk_wr_en_o   <= 1'b0;
            disk_wr_word_o <= 12'h000;
        end else begin
            disk_wr_en_o   <= wr_tick & hold_full & ~write_locked_i; // RULE_14
            disk_wr_word_o <= hold;
        end
    end

    // sticky flags; a start clears them but a same-cycle event still sets
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            start_chk         <= 1'b0;
            completion_flag   <= 1'b0;
            write_lock_bit    <= 1'b0;
            late_request_flag <= 1'b0;
            missing_disk_flag <= 1'b0;
            parity_flag       <= 1'b0;
        end else begin
            start_chk <= start_any;
            if (start_any) begin
                completion_flag   <= 1'b0;
                write_lock_bit    <= 1'b0;
                late_request_flag <= 1'b0;
                missing_disk_flag <= 1'b0;
                parity_flag       <= 1'b0;
            end
            if (rd_done || wr_done) begin
                completion_flag <= 1'b1;          // RULE_08 RULE_10
            end
            // selection outputs settle one cycle after the start
            if (start_chk && mode_wr && write_locked_i) begin
                write_lock_bit <= 1'b1;           // RULE_14
            end
            if ((rd_tick && break_request && !break_ack_i) ||
                (wr_tick && !hold_full && !last_pending)) begin
                late_request_flag <= 1'b1;        // RULE_18
            end
            if ((start_chk && !disk_present_i[addr[19:18]]) ||
                (advance && !disk_present_i[next_addr[19:18]])) begin
                missing_disk_flag <= 1'b1;        // RULE_19 RULE_23
            end
            if (rd_tick && parity_bad(disk_rd_word_i, disk_rd_parity_i)) begin
                parity_flag <= 1'b1;              // RULE_20
            end
        end
    end

    // enables, extension field and accumulator answers
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            error_irq_enable      <= 1'b0;
            origin_irq_enable     <= 1'b0;
            completion_irq_enable <= 1'b0;
            mem_ext               <= 2'h0;
            ac_clear_o            <= 1'b0;
            ac_load_o             <= 1'b0;
            ac_data_o             <= 12'h000;
        end else begin
            if (stat_load) begin
                error_irq_enable      <= ac_i[ST_EIE];
                origin_irq_enable     <= ac_i[ST_PIE];
                completion_irq_enable <= ac_i[ST_CIE];
                mem_ext               <= ac_i[ST_EXT_LSB +: 2];
            end
            ac_clear_o <= hi_read_clr | rd_clr | hi_load;  // RULE_03
            ac_load_o  <= any_read;
            ac_data_o  <= any_read ? ac_mux : 12'h000;
        end
    end

    // interrupt line: OR of every enabled condition
    assign irq_o = (error_irq_enable & err_any)                 // RULE_15 RULE_20 RULE_25
                 | (origin_irq_enable & origin_sync_flag)       // RULE_16
                 | (completion_irq_enable & completion_flag);   // RULE_17
    assign break_request_o            = break_request;
    assign buffer_hold_register_o     = hold;
    assign word_count_location_o      = WORD_COUNT_LOC;          // RULE_05
    assign current_address_location_o = CURRENT_ADDR_LOC;        // RULE_05
    assign mem_ext_o                  = mem_ext;
    assign disk_sel_o                 = addr[DISK_LSB +: 2];     // RULE_02
    assign track_sel_o                = addr[TRACK_LSB +: 7];    // RULE_02

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);

    chk_hi_read_top: assert property (ac_load_o && $past(io_opcode_i) == OP_HI_READ |-> ac_data_o[11:8] == 4'h0) // RULE_03
        else $error("high address read put bits in the top of AC");
    chk_write_req: assert property (start_wr |=> break_request_o) // RULE_07
        else $error("write start raised no break request");
    chk_lock_guard: assert property (disk_wr_en_o |-> !$past(write_locked_i)) // RULE_14
        else $error("write into a locked area");
    chk_read_end: assert property (rd_done && !start_any |=> completion_flag && state == ST_IDLE) // RULE_10
        else $error("read did not complete on overflow");
    chk_origin_hold: assert property ($rose(origin_sync_flag) |-> origin_sync_flag [*8]) // RULE_11
        else $error("origin flag dropped early");
    chk_sync_skip: assert property (start_any && origin_sync_flag |=> state == ST_SEARCH) // RULE_12
        else $error("origin start did not skip sync delay");
    chk_late_flag: assert property (rd_tick && break_request && !break_ack_i && !start_any |=> late_request_flag) // RULE_18
        else $error("unhonoured request not flagged late");
    chk_read_step: assert property (rd_tick && !start_any |=> addr == $past(next_addr)) // RULE_10
        else $error("read address did not advance");
    chk_done_irq: assert property (completion_flag && completion_irq_enable |-> irq_o) // RULE_17
        else $error("completion interrupt missing");
    chk_track_sync: assert property (advance && track_cross && !wr_done && !start_any |=> state == ST_SYNC) // RULE_24
        else $error("no resync after track change");

    cov_write_done: cover property (wr_done);
    cov_read_done: cover property (rd_done);
    cov_track_cross: cover property (advance && track_cross);
    cov_origin_start: cover property (start_any && origin_sync_flag);
endmodule

// ===== dbtc_cpu_model.sv
`timescale 1ns/1ps
// processor side of the break channel: answers each request after a short latency
module dbtc_cpu_model (
    input  wire logic        sys_clk_i,
    input  wire logic        req_i,
    input  wire logic        load_i,
    input  wire logic [11:0] cnt_i,
    output logic             ack_o = 1'b0,
    output logic             wco_o = 1'b0,
    output logic [11:0]      mb_o = 12'h000
);
    logic [11:0] wc = 12'h000;
    logic [11:0] ca = 12'h000;
    logic [1:0]  dly = 2'h0;
    wire         fire = req_i && !ack_o && !load_i && (dly == 2'h2);
    // a request is never answered twice; idle data toggles so stale words never look valid
    always @(posedge sys_clk_i) begin
        ack_o <= fire;
        wco_o <= fire && (wc == 12'hFFF);
        mb_o  <= fire ? 12'(ca + 12'h001) : ~mb_o;
        dly   <= (req_i && !ack_o) ? 2'(dly + 2'h1) : 2'h0;
        if (load_i) begin
            wc <= -cnt_i;
            ca <= 12'h3FF;
        end else if (fire) begin
            wc <= wc + 12'h001;
            ca <= ca + 12'h001;
        end
    end
endmodule

// ===== disk_break_transfer_control_tb.sv
`timescale 1ns/1ps
module disk_break_transfer_control_tb;
    import dbtc_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [3:0]  op = 4'h0;
    logic [2:0]  ph = 3'h0;
    logic [11:0] ac = 12'h000;
    logic        tick = 1'b0;
    logic        lock = 1'b0;
    logic        ld = 1'b0;
    logic [11:0] cnt = 12'h003;
    logic        rdp = 1'b1;
    logic [3:0]  present = 4'hF;
    logic [11:0] rdw = 12'h000;
    logic [11:0] last_wr = 12'h000;
    logic [11:0] hold, wword;
    logic [1:0]  mext, dsel;
    logic [6:0]  tsel;
    logic        ack, count_overflow_pulse, req, wr, irq, aload, aclr;
    logic [11:0] mb, adata, wcl, cal;
    int          n_fail = 0;
    int          tests_run = 0;
    int          n_wr = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    // disk spins freely, one word every eight clocks
    always #32 tick = ~tick;
    // count disk writes and keep the last word put on the disk
    always @(posedge sys_clk_i) begin
        if (wr === 1'b1) begin
            n_wr    <= n_wr + 1;
            last_wr <= wword;
        end
    end
    dbtc_top #(.ORG_DELAY_CYC(20), .ORG_WIDTH_CYC(40)) dut_u (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .io_opcode_i(op), .io_pulse_phase_i(ph),
        .ac_i(ac), .break_ack_i(ack), .count_overflow_pulse_i(count_overflow_pulse), .mb_i(mb),
        .disk_word_tick_i(tick), .disk_index_i(1'b0), .disk_rd_word_i(rdw),
        .disk_rd_parity_i(rdp), .write_locked_i(lock), .disk_present_i(present),
        .break_request_o(req), .buffer_hold_register_o(hold), .word_count_location_o(wcl),
        .current_address_location_o(cal), .mem_ext_o(mext), .disk_sel_o(dsel), .track_sel_o(tsel),
        .disk_wr_en_o(wr), .disk_wr_word_o(wword), .ac_data_o(adata), .ac_load_o(aload),
        .ac_clear_o(aclr), .irq_o(irq));
    dbtc_cpu_model cpu_u (.sys_clk_i(sys_clk_i), .req_i(req), .load_i(ld), .cnt_i(cnt),
        .ack_o(ack), .wco_o(count_overflow_pulse), .mb_o(mb));
    task automatic check(input string nm, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one instruction phase, held for exactly one sampling edge
    task automatic pulse(input logic [3:0] o, input logic [2:0] p, input logic [11:0] a);
        @(posedge sys_clk_i);
        op <= o;
        ph <= p;
        ac <= a;
        @(posedge sys_clk_i);
        ph <= 3'h0;
        #1;
    endtask
    task automatic t_high;
        check("wc_loc", 12'hFE8, wcl);
        check("ca_loc", 12'hFE9, cal);
        pulse(OP_HI_LOAD, 3'b001, 12'h0A5);
        pulse(OP_HI_LOAD, 3'b010, 12'h0A5);
        pulse(OP_HI_READ, 3'b001, 12'h000);
        check("ac_clear", 12'h001, {11'h0, aclr});
        pulse(OP_HI_READ, 3'b100, 12'h000);
        check("high_addr", 12'h025, adata);
    endtask
    // write three words, or a locked write; lk selects which, en the enables
    task automatic t_write(input logic lk, input logic [11:0] en, input int exp_wr);
        int w0;
        w0 = n_wr;
        lock <= lk;
        pulse(OP_STAT_LOAD, 3'b100, en);
        ld <= 1'b1;
        @(posedge sys_clk_i);
        ld <= 1'b0;
        pulse(OP_WRITE_START, 3'b001, 12'h010);
        // the last word is handed over before the end, so a locked run also passes the disk
        for (int i = 0; i < 30000 && count_overflow_pulse !== 1'b1; i++) @(posedge sys_clk_i);
        for (int i = 0; i < 30000 && irq !== 1'b1; i++) @(posedge sys_clk_i);
        check("irq", 12'h001, {11'h0, irq});
        repeat (100) @(posedge sys_clk_i);
        check("writes", exp_wr[11:0], 12'(n_wr - w0));
        check("mem_ext", {10'h0, en[11:10]}, {10'h0, mext});
        pulse(OP_STAT_READ, 3'b100, 12'h000);
        check("status", {11'h0, 1'b1}, {11'h0, lk ? adata[ST_WLOCK] : adata[ST_DONE]});
        if (!lk) begin
            check("wr_word", 12'h402, last_wr);
            pulse(OP_LOW_READ, 3'b100, 12'h000);
            check("last_addr", 12'h012, adata);
        end
    endtask
    // three words read from an absent disk with bad parity, started inside the origin mark
    task automatic t_read;
        present <= 4'h3;
        rdw     <= 12'h5A3;
        rdp     <= 1'b0;
        pulse(OP_STAT_LOAD, 3'b100, 12'h020);
        ld <= 1'b1;
        @(posedge sys_clk_i);
        ld <= 1'b0;
        for (int i = 0; i < 30000 && irq !== 1'b1; i++) @(posedge sys_clk_i);
        check("origin_irq", 12'h001, {11'h0, irq});
        pulse(OP_STAT_LOAD, 3'b100, 12'h040);
        pulse(OP_READ_START, 3'b001, 12'h010);
        // without the skip the target angle is missed and a whole turn passes
        for (int i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge sys_clk_i);
        check("sync_skip", 12'h001, {11'h0, irq});
        check("hold", 12'h5A3, hold);
        check("disk_sel", 12'h002, {10'h0, dsel});
        check("track_sel", 12'h04A, {5'h0, tsel});
        pulse(OP_STAT_READ, 3'b100, 12'h000);
        check("rd_status", 12'h341, adata & 12'hFFD);
        pulse(OP_LOW_READ, 3'b100, 12'h000);
        check("rd_last", 12'h013, adata);
    endtask
    task automatic conclude;
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #800000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        t_high();
        t_write(1'b0, 12'h840, 3);
        t_write(1'b1, 12'h010, 0);
        t_read();
        conclude();
    end
endmodule
